//--- design/rsds_top.v
// Reset strap capture and debug status pin driver with APB registers
//
// Overview of operation
// - Trace code 111 stall, 110 branch with PC, 101 branch without, 100 exception.
// - Trace code 011 sequential, 010 stall-time trace, 001 trigger, 000 debug mode.
// - Test mode select is sampled on each rising test clock edge.
// - During start or acknowledge, source flag high for CPU, low for DMA.
// - Acknowledge flag goes low for every data acknowledge to CPU or DMA.
// - Start strobe goes low at transaction start with block address on data 31:4.
// - During start or acknowledge, instruction/data flag low for data, high for instruction.
// - At cold reset pins give config bits 6:0; bit 3 picks byte order.
// - Config bits 2:0 choose core clock multiplier 2, 3 or 4; rest reserved.
// - Config bit 6 low enables, high disables the timer interrupt.
// - Config bits 9:8 choose boot memory width 8, 16 or 32 bits.
// - All configuration values are captured by the active-low cold reset.
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "rsds_defines.vh"

module rsds_top (
	// Clock, reset, enable
	input  wire        clk_i,
	input  wire        sys_rst_i,
	input  wire        clk_en_i,
	// APB slave
	input  wire        psel_i,
	input  wire        penable_i,
	input  wire        pwrite_i,
	input  wire [11:0] paddr_i,
	input  wire [31:0] pwdata_i,
	output wire [31:0] prdata_o,
	output wire        pready_o,
	output wire        pslverr_o,
	// Cold reset and address-pin straps (bits 19:17)
	input  wire        cold_rst_n_i,
	input  wire [2:0]  strap_addr_i,
	// Debug test port
	input  wire        test_clk_i,
	input  wire        test_mode_sel_i,
	// Core trace events
	input  wire        trc_debug_mode_i,
	input  wire        trc_exception_i,
	input  wire        trc_branch_pc_i,
	input  wire        trc_branch_nopc_i,
	input  wire        trc_trigger_i,
	input  wire        trc_stall_trace_i,
	input  wire        trc_stall_i,
	// Core transaction events
	input  wire        txn_start_i,
	input  wire        txn_dma_i,
	input  wire        txn_data_i,
	input  wire [27:0] txn_block_addr_i,
	input  wire        ack_i,
	input  wire        ack_dma_i,
	input  wire        ack_data_i,
	// Shared trace status pins
	input  wire [2:0]  trace_status_i,
	output wire [2:0]  trace_status_o,
	output wire [2:0]  trace_status_oe_o,
	// Shared flag pins: source, acknowledge, start, instruction/data
	input  wire        src_n_i,
	output wire        src_n_o,
	output wire        src_n_oe_o,
	input  wire        ack_n_i,
	output wire        ack_n_o,
	output wire        ack_n_oe_o,
	input  wire        start_n_i,
	output wire        start_n_o,
	output wire        start_n_oe_o,
	input  wire        instr_data_n_i,
	output wire        instr_data_n_o,
	output wire        instr_data_n_oe_o,
	// Memory data bus, block address part
	output wire [27:0] mem_data_hi_o,
	// Decoded configuration
	output wire [9:0]  cfg_word_o,
	output wire [2:0]  core_mult_o,
	output wire        mult_reserved_o,
	output wire        byte_order_select_o,
	output wire        timer_irq_mask_o,
	output wire [1:0]  boot_width_o,
	output wire        cold_done_o
);

	// ==========================================================
	// Functions

	// Priority encode of core trace events
	function [2:0] rsds_trace_code;
		input dbg, exc, bpc, bnopc, trig, sttr, trace_code_stall;
		begin
			if (dbg)
				rsds_trace_code = `RSDS_TRACE_DEBUG_MODE;
			else if (exc)
				rsds_trace_code = `RSDS_TRACE_EXCEPTION;
			else if (bpc)
				rsds_trace_code = `RSDS_TRACE_BRANCH_PC;
			else if (bnopc)
				rsds_trace_code = `RSDS_TRACE_BRANCH_NOPC;
			else if (trig)
				rsds_trace_code = `RSDS_TRACE_TRIGGER;
			else if (sttr)
				rsds_trace_code = `RSDS_TRACE_STALL_TRACE;
			else if (trace_code_stall)
				rsds_trace_code = `RSDS_TRACE_STALL;
			else
				rsds_trace_code = `RSDS_TRACE_SEQUENTIAL;
		end
	endfunction

	// Flags a configuration word that breaks the reserved encodings
	function rsds_cfg_bad;
		input [9:0] cfg;
		begin
			rsds_cfg_bad = (cfg[`RSDS_CFG_MULT_HI:`RSDS_CFG_MULT_LO] > `RSDS_MULT_X4)
				| cfg[`RSDS_CFG_RSV4] | cfg[`RSDS_CFG_RSV5] | ~cfg[`RSDS_CFG_RSV7]
				| (cfg[`RSDS_CFG_WID_HI:`RSDS_CFG_WID_LO] == `RSDS_WID_RSV);
		end
	endfunction

	// ==========================================================
	// Registers
	reg [1:0]  ctrl_q;
	reg        strap_err_q;
	reg        cold_done_q;
	reg        cold_seen_q;
	reg [9:0]  cfg_q;
	reg [2:0]  mult_q;
	reg        mult_rsv_q;
	reg        tclk_prev_q;
	reg        tms_q;
	reg [2:0]  trace_q;
	reg        src_n_q;
	reg        ack_n_q;
	reg        start_n_q;
	reg        id_n_q;
	reg [27:0] blk_addr_q;
	reg        pin_oe_q;
	reg [31:0] prdata_q;
	reg        pready_q;
	reg        pslverr_q;

	wire [9:0] pin_cfg;
	wire       apb_setup;
	wire       apb_wr;
	wire       err_clr;
	wire       strap_take;
	wire [2:0] pin_mult;
	reg [31:0] rd_mux;
	reg        rd_err;

	// Straps as presented on the shared pins and address pins
	assign pin_cfg = {strap_addr_i, src_n_i, start_n_i, ack_n_i,
		instr_data_n_i, trace_status_i};
	assign strap_take = ~cold_rst_n_i & ~pin_oe_q;   // Never sample our own drive
	assign pin_mult   = pin_cfg[`RSDS_CFG_MULT_HI:`RSDS_CFG_MULT_LO];

	assign apb_setup = psel_i & ~penable_i;
	// A write lands only at the completing access edge
	assign apb_wr    = psel_i & penable_i & pready_q & pwrite_i & ~pslverr_q;
	assign err_clr   = apb_wr & (paddr_i == `RSDS_OFS_STATUS) & pwdata_i[`RSDS_ST_STRAP_ERR];

	// ==========================================================
	// Cold reset strap capture

	// Pins are taken while cold reset is low and our drivers are off, so the
	// value held is the one present at the last edge before release.
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			cfg_q       <= `RSDS_CFG_RST;
			mult_q      <= 3'h2;
			mult_rsv_q  <= 1'b0;
			cold_done_q <= 1'b0;
			cold_seen_q <= 1'b0;
		end else if (clk_en_i) begin
			if (strap_take) begin
				cfg_q      <= pin_cfg;
				mult_q     <= (pin_mult > `RSDS_MULT_X4) ? 3'h0 : pin_mult + 3'h2;
				mult_rsv_q <= (pin_mult > `RSDS_MULT_X4);
			end
			if (!cold_rst_n_i) begin
				cold_done_q <= 1'b0;
				cold_seen_q <= 1'b1;
			end else if (cold_seen_q) begin
				cold_done_q <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Pin ownership

	// Drivers stay off until two cycles after release so the strap driver and
	// the device never fight on the shared pins.
	always @(posedge clk_i) begin
		if (sys_rst_i)
			pin_oe_q <= 1'b0;
		else if (clk_en_i)
			pin_oe_q <= cold_rst_n_i & cold_done_q & ctrl_q[`RSDS_CTRL_PIN_EN];
	end

	// ==========================================================
	// Test mode select sampling

	// Test clock is a plain synchronous input; its rising edge is found here
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			tclk_prev_q <= 1'b0;
			tms_q       <= 1'b1;
		end else if (clk_en_i) begin
			tclk_prev_q <= test_clk_i;
			if (test_clk_i & ~tclk_prev_q)
				tms_q <= test_mode_sel_i;
		end
	end

	// ==========================================================
	// Debug status outputs

	// Start takes precedence over acknowledge for the source and type flags
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			trace_q    <= `RSDS_TRACE_SEQUENTIAL;
			start_n_q  <= 1'b1;
			ack_n_q    <= 1'b1;
			src_n_q    <= 1'b1;
			id_n_q     <= 1'b1;
			blk_addr_q <= 28'h0000000;
		end else if (clk_en_i) begin
			trace_q   <= rsds_trace_code(trc_debug_mode_i, trc_exception_i,
				trc_branch_pc_i, trc_branch_nopc_i, trc_trigger_i,
				trc_stall_trace_i, trc_stall_i);
			start_n_q <= ~txn_start_i;
			ack_n_q   <= ~ack_i;
			if (txn_start_i) begin
				src_n_q    <= ~txn_dma_i;
				id_n_q     <= ~txn_data_i;
				blk_addr_q <= txn_block_addr_i;
			end else if (ack_i) begin
				src_n_q <= ~ack_dma_i;
				id_n_q  <= ~ack_data_i;
			end else begin
				src_n_q <= 1'b1;
				id_n_q  <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Control and sticky strap error

	// A bad strap seen in the same cycle as a clear keeps the flag set
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			ctrl_q      <= `RSDS_CTRL_RST;
			strap_err_q <= 1'b0;
		end else if (clk_en_i) begin
			if (apb_wr & (paddr_i == `RSDS_OFS_CTRL))
				ctrl_q <= pwdata_i[1:0];
			if (strap_take & rsds_cfg_bad(pin_cfg))
				strap_err_q <= 1'b1;
			else if (err_clr)
				strap_err_q <= 1'b0;
		end
	end

	// ==========================================================
	// APB read decode
	always @* begin
		rd_mux = 32'h00000000;
		rd_err = 1'b0;
		case (paddr_i)
			`RSDS_OFS_CTRL:
				rd_mux = {30'h00000000, ctrl_q};
			`RSDS_OFS_STATUS:
				rd_mux = {29'h00000000, strap_err_q, tms_q, cold_done_q};
			`RSDS_OFS_STRAP:
				rd_mux = {22'h000000, cfg_q};
			`RSDS_OFS_TRACE:
				rd_mux = {25'h0000000, id_n_q, start_n_q, ack_n_q, src_n_q, trace_q};
			default:
				rd_err = 1'b1;
		endcase
	end

	// ==========================================================
	// APB answer: data and ready are loaded in setup, so access ends in one cycle
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			prdata_q  <= 32'h00000000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else if (clk_en_i) begin
			if (apb_setup) begin
				prdata_q  <= pwrite_i ? 32'h00000000 : rd_mux;
				pready_q  <= 1'b1;
				pslverr_q <= rd_err;
			end else begin
				prdata_q  <= 32'h00000000;
				pready_q  <= 1'b0;
				pslverr_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Output assignments
	assign prdata_o            = prdata_q;
	assign pready_o            = pready_q;
	assign pslverr_o           = pslverr_q;
	assign trace_status_o      = trace_q;
	assign trace_status_oe_o   = {3{pin_oe_q}};
	assign src_n_o             = src_n_q;
	assign src_n_oe_o          = pin_oe_q;
	assign ack_n_o             = ack_n_q;
	assign ack_n_oe_o          = pin_oe_q;
	assign start_n_o           = start_n_q;
	assign start_n_oe_o        = pin_oe_q;
	assign instr_data_n_o      = id_n_q;
	assign instr_data_n_oe_o   = pin_oe_q;
	assign mem_data_hi_o       = blk_addr_q;
	assign cfg_word_o          = cfg_q;
	assign core_mult_o         = mult_q;
	assign mult_reserved_o     = mult_rsv_q;
	assign byte_order_select_o = cfg_q[`RSDS_CFG_ORDER];
	assign timer_irq_mask_o    = cfg_q[`RSDS_CFG_TMR];
	assign boot_width_o        = cfg_q[`RSDS_CFG_WID_HI:`RSDS_CFG_WID_LO];
	assign cold_done_o         = cold_done_q;

endmodule // rsds_top
`default_nettype wire

//--- pkg/rsds_defines.vh
// Constants for the reset strap and debug status block
`ifndef RSDS_DEFINES_VH
`define RSDS_DEFINES_VH

// ==========================================================
// APB register offsets (byte addresses)
`define RSDS_OFS_CTRL        12'h000
`define RSDS_OFS_STATUS      12'h004
`define RSDS_OFS_STRAP       12'h008
`define RSDS_OFS_TRACE       12'h00c

// ==========================================================
// Control register fields and reset value
`define RSDS_CTRL_PIN_EN     0
`define RSDS_CTRL_RST        2'h1

// ==========================================================
// Status register fields
`define RSDS_ST_COLD_DONE    0
`define RSDS_ST_TMS          1
`define RSDS_ST_STRAP_ERR    2

// ==========================================================
// Configuration word field positions
`define RSDS_CFG_MULT_LO     0
`define RSDS_CFG_MULT_HI     2
`define RSDS_CFG_ORDER       3
`define RSDS_CFG_RSV4        4
`define RSDS_CFG_RSV5        5
`define RSDS_CFG_TMR         6
`define RSDS_CFG_RSV7        7
`define RSDS_CFG_WID_LO      8
`define RSDS_CFG_WID_HI      9
`define RSDS_CFG_RST         10'h080

// ==========================================================
// Strap encodings
`define RSDS_MULT_X2         3'h0
`define RSDS_MULT_X3         3'h1
`define RSDS_MULT_X4         3'h2
`define RSDS_WID_8           2'h0
`define RSDS_WID_16          2'h1
`define RSDS_WID_32          2'h2
`define RSDS_WID_RSV         2'h3

// ==========================================================
// Trace status codes
`define RSDS_TRACE_STALL         3'h7
`define RSDS_TRACE_BRANCH_PC     3'h6
`define RSDS_TRACE_BRANCH_NOPC   3'h5
`define RSDS_TRACE_EXCEPTION     3'h4
`define RSDS_TRACE_SEQUENTIAL    3'h3
`define RSDS_TRACE_STALL_TRACE   3'h2
`define RSDS_TRACE_TRIGGER       3'h1
`define RSDS_TRACE_DEBUG_MODE    3'h0

`endif

//--- tb/rsds_strap_model.sv
// Board strap driver and debug probe model on the shared pins
`timescale 1ns/1ps
`default_nettype none
module rsds_strap_model (
	// Clock and cold reset
	input  wire logic       clk_i,
	input  wire logic       cold_rst_n_i,
	// Strap pattern and device drive
	input  wire logic [6:0] strap_i,
	input  wire logic [6:0] dev_o_i,
	input  wire logic [6:0] dev_oe_i,
	// Resolved pin levels
	output logic      [6:0] pin_o
);
	logic [6:0] last_q = 7'h0;
	logic [6:0] strap_d;
	// Reserved straps 4 and 5 are tied low on the board
	assign strap_d = {strap_i[6], 2'h0, strap_i[3:0]};
	// Device wins while it drives; straps only while cold reset is low
	assign pin_o = (dev_oe_i & dev_o_i) | (~dev_oe_i & (cold_rst_n_i ? ~last_q : strap_d));
	// Floating pins wander so a stale level never passes for a drive
	always @(posedge clk_i) last_q <= pin_o;
endmodule // rsds_strap_model
`default_nettype wire

//--- tb/rsds_checker.sv
// Port-level assertions for the strap and debug status block
`timescale 1ns/1ps
`default_nettype none
module rsds_checker (
	// Clock and control
	input wire logic        clk_i,
	input wire logic        sys_rst_i,
	input wire logic        clk_en_i,
	input wire logic        cold_rst_n_i,
	// Bus
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	// Core events
	input wire logic        trc_debug_mode_i,
	input wire logic        trc_exception_i,
	input wire logic        txn_start_i,
	input wire logic        txn_dma_i,
	input wire logic        txn_data_i,
	input wire logic [27:0] txn_block_addr_i,
	input wire logic        ack_i,
	// Pins and decoded outputs
	input wire logic [2:0]  trace_status_o,
	input wire logic [2:0]  trace_status_oe_o,
	input wire logic        src_n_o,
	input wire logic        ack_n_o,
	input wire logic        start_n_o,
	input wire logic        start_n_oe_o,
	input wire logic        instr_data_n_o,
	input wire logic [27:0] mem_data_hi_o,
	input wire logic [9:0]  cfg_word_o,
	input wire logic [2:0]  core_mult_o,
	input wire logic        byte_order_select_o,
	input wire logic        timer_irq_mask_o,
	input wire logic [1:0]  boot_width_o,
	input wire logic        cold_done_o
);
	// ==========================================================
	// Assertions
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	ready_after_setup_a: assert property (psel_i && !penable_i && clk_en_i |=> pready_o)
		else $error("ready missing after setup");
	ready_one_cycle_a: assert property (pready_o && clk_en_i |=> !pready_o)
		else $error("ready held too long");
	error_with_ready_a: assert property (pslverr_o |-> pready_o)
		else $error("error without ready");
	debug_code_a: assert property (clk_en_i && trc_debug_mode_i |=> trace_status_o == 3'h0)
		else $error("debug mode code wrong");
	exc_code_a: assert property (clk_en_i && trc_exception_i && !trc_debug_mode_i |=>
		trace_status_o == 3'h4) else $error("exception code wrong");
	start_source_a: assert property (clk_en_i && txn_start_i |=>
		!start_n_o && src_n_o == !$past(txn_dma_i)) else $error("start source wrong");
	start_addr_a: assert property (clk_en_i && txn_start_i |=>
		mem_data_hi_o == $past(txn_block_addr_i)) else $error("block address wrong");
	start_kind_a: assert property (clk_en_i && txn_start_i |=>
		instr_data_n_o == !$past(txn_data_i)) else $error("kind flag wrong");
	ack_flag_a: assert property (clk_en_i && ack_i |=> !ack_n_o)
		else $error("ack flag missing");
	mult_decode_a: assert property (cold_rst_n_i [*3] ##0 cold_done_o |->
		core_mult_o == (cfg_word_o[2:0] < 3'h3 ? cfg_word_o[2:0] + 3'h2 : 3'h0))
		else $error("multiplier decode wrong");
	field_decode_a: assert property (cold_rst_n_i [*3] ##0 cold_done_o |->
		byte_order_select_o == cfg_word_o[3] && timer_irq_mask_o == cfg_word_o[6]
		&& boot_width_o == cfg_word_o[9:8]) else $error("field decode wrong");
	pins_released_a: assert property (!cold_rst_n_i [*2] |->
		!start_n_oe_o && trace_status_oe_o == 3'h0) else $error("pins driven in cold reset");
	// Main scenarios
	cover property ($rose(cold_done_o));
	cover property (pslverr_o);
	cover property (!start_n_o && !src_n_o);
endmodule // rsds_checker
bind rsds_top rsds_checker chk (.*);
`default_nettype wire

//--- tb/reset_strap_and_debug_status_test.sv
// Self-checking bench for the reset strap and debug status block
`timescale 1ns/1ps
`default_nettype none
module reset_strap_and_debug_status_test;
	logic clk_i = 0, sys_rst_i = 1, clk_en_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
	logic cold_rst_n_i = 1, test_clk_i = 0, test_mode_sel_i = 1;
	logic trc_debug_mode_i = 0, trc_exception_i = 0, trc_branch_pc_i = 0, trc_branch_nopc_i = 0;
	logic trc_trigger_i = 0, trc_stall_trace_i = 0, trc_stall_i = 0;
	logic txn_start_i = 0, txn_dma_i = 0, txn_data_i = 0, ack_i = 0, ack_dma_i = 0, ack_data_i = 0;
	logic [11:0] paddr_i = 12'h0;
	logic [31:0] pwdata_i = 32'h0, rd;
	logic [27:0] txn_block_addr_i = 28'h0;
	logic [2:0]  strap_addr_i = 3'h1;
	logic [6:0]  strap = 7'h0;
	logic [9:0]  cw;
	logic        er;
	wire  [31:0] prdata_o;
	wire  [27:0] mem_data_hi_o;
	wire  [9:0]  cfg_word_o;
	wire  [2:0]  trace_status_i, trace_status_o, trace_status_oe_o, core_mult_o;
	wire  [1:0]  boot_width_o;
	wire pready_o, pslverr_o, src_n_i, src_n_o, src_n_oe_o, ack_n_i, ack_n_o, ack_n_oe_o;
	wire start_n_i, start_n_o, start_n_oe_o, instr_data_n_i, instr_data_n_o, instr_data_n_oe_o;
	wire mult_reserved_o, byte_order_select_o, timer_irq_mask_o, cold_done_o;
	int err_count = 0, n_compared = 0;
	localparam logic [2:0] TC [8] = '{3'h0, 3'h4, 3'h6, 3'h5, 3'h1, 3'h2, 3'h7, 3'h3};
	localparam logic [9:0] CW [4] = '{10'h080, 10'h1c9, 10'h282, 10'h387};

	rsds_top dut (.*);
	rsds_strap_model far (.clk_i, .cold_rst_n_i, .strap_i(strap),
		.dev_o_i({src_n_o, start_n_o, ack_n_o, instr_data_n_o, trace_status_o}),
		.dev_oe_i({src_n_oe_o, start_n_oe_o, ack_n_oe_o, instr_data_n_oe_o, trace_status_oe_o}),
		.pin_o({src_n_i, start_n_i, ack_n_i, instr_data_n_i, trace_status_i}));

	always #10 clk_i = ~clk_i;

	// ==========================================================
	// Shared tasks
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	// One bus transfer; waits for ready under a bound
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		psel_i <= 1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1;
		// Ready is judged as sampled at each edge, before the slave updates it
		@(posedge clk_i);
		while (pready_o !== 1'b1 && k < 50) begin
			@(posedge clk_i);
			k++;
		end
		if (pready_o !== 1'b1) err_count++;
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 0;
		penable_i <= 0;
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		apb(0, a, 32'h0);
		chk("prdata", rd, e);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Watchdog: the sequence needs well under a thousand cycles
	initial begin
		#100us;
		err_count++;
		report_and_stop;
	end

	// ==========================================================
	// Test sequence
	initial begin
		repeat (6) @(posedge clk_i);
		sys_rst_i <= 0;
		#1;
		chk("cfg_word", cfg_word_o, 10'h080);
		chk("trace", trace_status_o, 3'h3);
		chk("oe", {trace_status_oe_o, start_n_oe_o}, 4'h0);
		chk("flag_oe", {src_n_oe_o, ack_n_oe_o, instr_data_n_oe_o}, 3'h0);
		rd_chk(12'h000, 32'h1);
		rd_chk(12'h004, 32'h2);
		$display("reset test done");
		// Cold captures, reserved codes among them
		for (int i = 0; i < 4; i++) begin
			cw = CW[i];
			@(posedge clk_i);
			strap <= cw[6:0];
			strap_addr_i <= cw[9:7];
			cold_rst_n_i <= 0;
			repeat (3) @(posedge clk_i);
			cold_rst_n_i <= 1;
			tick(4);
			chk("cfg_word", cfg_word_o, cw);
			chk("mult", core_mult_o, cw[2:0] < 3 ? cw[2:0] + 3'h2 : 3'h0);
			chk("mult_rsv", mult_reserved_o, cw[2:0] > 2);
			chk("order", byte_order_select_o, cw[3]);
			chk("tmr_mask", timer_irq_mask_o, cw[6]);
			chk("width", boot_width_o, cw[9:8]);
			chk("oe", {cold_done_o, trace_status_oe_o}, 4'hf);
			chk("flag_oe", {src_n_oe_o, ack_n_oe_o, start_n_oe_o, instr_data_n_oe_o}, 4'hf);
			rd_chk(12'h008, {22'h0, cw});
			rd_chk(12'h004, {29'h0, i == 3, 2'h3});
		end
		$display("strap test done");
		// All events down to none, so priority shows too
		for (int j = 0; j < 8; j++) begin
			@(posedge clk_i);
			{trc_debug_mode_i, trc_exception_i, trc_branch_pc_i, trc_branch_nopc_i,
				trc_trigger_i, trc_stall_trace_i, trc_stall_i} <= 7'h7f >> j;
			tick(1);
			chk("trace", trace_status_o, TC[j]);
			chk("trace_pin", trace_status_i, TC[j]);
		end
		// Start then acknowledge back to back, every source and kind
		for (int k = 0; k < 4; k++) begin
			@(posedge clk_i);
			txn_start_i <= 1;
			{txn_dma_i, ack_dma_i} <= {2{k[0]}};
			{txn_data_i, ack_data_i} <= {2{k[1]}};
			txn_block_addr_i <= {26'h1696969, k[1:0]};
			@(posedge clk_i);
			txn_start_i <= 0;
			ack_i <= 1;
			#1;
			chk("start", {start_n_o, src_n_o, instr_data_n_o}, {1'b0, ~k[0], ~k[1]});
			chk("block", mem_data_hi_o, txn_block_addr_i);
			@(posedge clk_i);
			ack_i <= 0;
			#1;
			chk("ack", {ack_n_o, start_n_o, src_n_i, instr_data_n_i}, {2'b01, ~k[0], ~k[1]});
		end
		$display("flag test done");
		// Pin enable off, unmapped and read-only places
		apb(1, 12'h000, 32'h0);
		tick(1);
		chk("oe", trace_status_oe_o, 3'h0);
		rd_chk(12'h00c, 32'h7b);
		apb(1, 12'h010, 32'hffffffff);
		chk("slverr", er, 1'b1);
		rd_chk(12'h010, 32'h0);
		apb(1, 12'h008, 32'h0);
		rd_chk(12'h008, 32'h387);
		apb(1, 12'h000, 32'h1);
		// Mode select taken on a rising test clock, then clear strap error
		@(posedge clk_i);
		test_mode_sel_i <= 0;
		@(posedge clk_i);
		test_clk_i <= 1;
		repeat (2) @(posedge clk_i);
		test_clk_i <= 0;
		test_mode_sel_i <= 1;
		rd_chk(12'h004, 32'h5);
		apb(1, 12'h004, 32'h4);
		rd_chk(12'h004, 32'h1);
		$display("register test done");
		// Enable low freezes the trace pins while an event is up
		@(posedge clk_i);
		clk_en_i <= 0;
		trc_exception_i <= 1;
		tick(2);
		chk("frozen", trace_status_o, 3'h3);
		@(posedge clk_i);
		clk_en_i <= 1;
		tick(1);
		chk("trace", trace_status_o, 3'h4);
		@(posedge clk_i);
		trc_exception_i <= 0;
		$display("enable test done");
		report_and_stop;
	end
endmodule // reset_strap_and_debug_status_test
`default_nettype wire
